// file: logic/bridge_pins_pkg.sv
// constants and carrier types for the pin port and secondary clock gating
// assumes all logic runs on the primary pci clock, mclk
package bridge_pins_pkg;

	// configuration dword addresses (byte address of the aligned dword)
	localparam logic [7:0] DW_PIN_ADDR = 8'h64;
	localparam logic [7:0] DW_CLK_ADDR = 8'h68;

	// byte addresses of the registers inside those dwords
	localparam logic [7:0] PIN_VALUE_BYTE = 8'h65;
	localparam logic [7:0] PIN_DRIVER_BYTE = 8'h66;
	localparam logic [7:0] PIN_INPUT_BYTE = 8'h67;
	localparam logic [7:0] CLK_GATE_BYTE = 8'h68;

	// byte lanes within a dword
	localparam int LANE_VALUE = 1;
	localparam int LANE_DRIVER = 2;
	localparam int LANE_INPUT = 3;
	localparam int LANE_CLK_LO = 0;
	localparam int LANE_CLK_HI = 1;

	// field positions
	localparam int VAL_CLR_LSB = 8;
	localparam int VAL_SET_LSB = 12;
	localparam int DRV_CLR_LSB = 16;
	localparam int DRV_SET_LSB = 20;
	localparam int IN_RSVD_LSB = 24;
	localparam int IN_PIN_LSB = 28;
	localparam int CLK_RSVD_LSB = 14;

	localparam int PIN_N = 4;
	localparam int SLOT_N = 4;
	localparam int DEV_N = 6;
	localparam int CLK_OUT_N = SLOT_N + DEV_N;
	localparam int CLK_DIS_W = 2 * SLOT_N + DEV_N;

	// values after reset
	localparam logic [3:0] PIN_NIBBLE_RST = 4'h0;
	localparam logic [3:0] IN_RSVD_VAL = 4'h0;
	localparam logic [13:0] CLK_DIS_RST = 14'h0000;
	localparam logic [1:0] CLK_RSVD_VAL = 2'h3;

	// serial load of the clock disables: one bit per strobe, bit 0 first
	localparam int SER_LEN = 14;
	localparam logic [3:0] SER_CNT_RST = 4'h0;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [3:0] be_n;
		logic [31:0] wdata;
	} cfg_req_t;

	typedef struct packed {
		logic valid;
		logic data;
	} ser_bit_t;

endpackage

// file: logic/clock_gate_cell.sv
// one gated secondary clock output
// assumes ph_next is the divided clock phase the output follows next cycle
`timescale 1ns/1ps
module clock_gate_cell import bridge_pins_pkg::*; (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ph_next,
	input wire logic dis,
	output logic clk_o
);
	logic en_q;
	logic out_q;

	// enable only changes when the output is about to be high, so a low
	// phase is either whole or absent: no runt pulses
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			en_q <= 1'b1;
		end else if (ph_next) begin
			en_q <= ~dis;
		end
	end

	// a stopped output is held high
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			out_q <= 1'b1;
		end else begin
			out_q <= ph_next | ~en_q;
		end
	end

	assign clk_o = out_q;
endmodule

// file: logic/serial_disable_loader.sv
// collects the clock disable word shifted in during secondary bus reset
// assumes board logic presents one bit per strobe, bit 0 first
`timescale 1ns/1ps
module serial_disable_loader import bridge_pins_pkg::*; #(
	parameter int LEN = SER_LEN
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic sec_rst,
	input wire ser_bit_t ser_in,
	output logic load,
	output logic [LEN-1:0] word
);
	logic [LEN-1:0] shift_q;
	logic [3:0] cnt_q;
	logic done_q;
	logic load_q;

	// fixed length and order for the stream
	always_ff @(posedge mclk) begin
		if (!rst_n || !sec_rst) begin
			cnt_q <= SER_CNT_RST;
			done_q <= 1'b0;
		end else if (ser_in.valid && !done_q) begin
			if (cnt_q == 4'(LEN - 1)) begin
				done_q <= 1'b1;
			end
			cnt_q <= cnt_q + 4'h1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			shift_q <= '0;
		end else if (sec_rst && ser_in.valid && !done_q) begin
			shift_q <= {ser_in.data, shift_q[LEN-1:1]};
		end
	end

	// one pulse when the last bit lands
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			load_q <= 1'b0;
		end else begin
			load_q <= sec_rst && ser_in.valid && !done_q &&
				(cnt_q == 4'(LEN - 1));
		end
	end

	assign load = load_q;
	assign word = shift_q;
endmodule

// file: logic/bridge_pins_and_slot_clock_gating.sv
// pin port and secondary clock gating in bridge configuration space
// assumes configuration accesses arrive as one-cycle strobes on mclk,
// with active low byte enables as on the primary bus
`timescale 1ns/1ps

// What this block does
// - write-1 clear field drives enabled pins low
// - write-1 set field drives enabled pins high
// - pins change cycle after write completes
// - disabled drivers stay undriven always
// - writing zeros changes nothing
// - set/clear fields read last written value
// - write-1 enable clear tristates pin driver
// - write-1 enable set drives held value
// - after reset enables zero, pins input
// - input field samples pins each cycle
// - reserved input nibble reads zero
// - slot clock stops only when both bits set
// - bits 8-12 stop device clocks 4-8
// - bit 13 stops feedback clock 9
// - secondary reset loads disables from stream
// - two top clock bits read ones
module bridge_pins_and_slot_clock_gating import bridge_pins_pkg::*; #(
	parameter int PINS = PIN_N,
	parameter int CLKS = CLK_OUT_N
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire cfg_req_t cfg_req,
	output logic [31:0] cfg_rdata,
	output logic cfg_rvalid,
	input wire logic [PINS-1:0] gpio_in,
	output logic [PINS-1:0] gpio_out,
	output logic [PINS-1:0] gpio_oe_n,
	input wire logic sec_rst,
	input wire ser_bit_t ser_in,
	output logic [CLKS-1:0] s_clk_o
);
	typedef enum logic [1:0] {
		PH_HIGH = 2'b01,
		PH_LOW = 2'b10
	} phase_t;

	logic [7:0] dw_addr;
	logic [3:0] lane;
	logic hit_pin;
	logic hit_clk;
	logic wr_val;
	logic wr_drv;
	logic wr_clk_lo;
	logic wr_clk_hi;

	logic [PINS-1:0] val_q;
	logic [PINS-1:0] val_clr_q;
	logic [PINS-1:0] val_set_q;
	logic [PINS-1:0] drv_q;
	logic [PINS-1:0] drv_clr_q;
	logic [PINS-1:0] drv_set_q;
	logic [PINS-1:0] in_q;
	logic [PINS-1:0] out_q;
	logic [PINS-1:0] oe_n_q;
	logic [CLK_DIS_W-1:0] dis_q;
	logic [31:0] rdata_q;
	logic rvalid_q;

	logic [PINS-1:0] w_val_clr;
	logic [PINS-1:0] w_val_set;
	logic [PINS-1:0] w_drv_clr;
	logic [PINS-1:0] w_drv_set;
	logic [PINS-1:0] val_d;
	logic [PINS-1:0] drv_d;

	logic ser_load;
	logic [CLK_DIS_W-1:0] ser_word;
	logic [CLKS-1:0] gate_dis;
	// read images and the per-group clock stops
	logic [CLK_DIS_W-1:0] dis_d;
	logic [31:0] pin_img;
	logic [31:0] clk_img;
	logic [SLOT_N-1:0] slot_stop;
	logic [DEV_N-1:0] dev_stop;
	phase_t ph_q;
	phase_t ph_d;
	logic ph_next;

	// decode: dword address plus active low lane enables
	assign dw_addr = {cfg_req.addr[7:2], 2'b00};
	assign lane = ~cfg_req.be_n;
	assign hit_pin = (dw_addr == DW_PIN_ADDR);
	assign hit_clk = (dw_addr == DW_CLK_ADDR);

	// write strobes per register; lanes outside a register are ignored
	always_comb begin
		wr_val = 1'b0;
		wr_drv = 1'b0;
		wr_clk_lo = 1'b0;
		wr_clk_hi = 1'b0;
		if (cfg_req.wr) begin
			case (dw_addr)
				DW_PIN_ADDR: begin
					wr_val = lane[LANE_VALUE];
					wr_drv = lane[LANE_DRIVER];
				end
				DW_CLK_ADDR: begin
					wr_clk_lo = lane[LANE_CLK_LO];
					wr_clk_hi = lane[LANE_CLK_HI];
				end
				default: begin
					wr_val = 1'b0;
				end
			endcase
		end
	end

	assign w_val_clr = cfg_req.wdata[VAL_CLR_LSB +: PINS];
	assign w_val_set = cfg_req.wdata[VAL_SET_LSB +: PINS];
	assign w_drv_clr = cfg_req.wdata[DRV_CLR_LSB +: PINS];
	assign w_drv_set = cfg_req.wdata[DRV_SET_LSB +: PINS];

	// zero bits keep their state; a one in both set and clear ends set
	always_comb begin
		val_d = val_q;
		drv_d = drv_q;
		if (wr_val) begin
			val_d = (val_q & ~w_val_clr) | w_val_set;
		end
		if (wr_drv) begin
			drv_d = (drv_q & ~w_drv_clr) | w_drv_set;
		end
	end

	// held output data, kept even while the driver is off
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			val_q <= PIN_NIBBLE_RST;
		end else begin
			val_q <= val_d;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			drv_q <= PIN_NIBBLE_RST;
		end else begin
			drv_q <= drv_d;
		end
	end

	// readback of the last written field values
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			val_clr_q <= PIN_NIBBLE_RST;
		end else if (wr_val) begin
			val_clr_q <= w_val_clr;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			val_set_q <= PIN_NIBBLE_RST;
		end else if (wr_val) begin
			val_set_q <= w_val_set;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			drv_clr_q <= PIN_NIBBLE_RST;
		end else if (wr_drv) begin
			drv_clr_q <= w_drv_clr;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			drv_set_q <= PIN_NIBBLE_RST;
		end else if (wr_drv) begin
			drv_set_q <= w_drv_set;
		end
	end

	// pins follow the new state on the cycle after the write strobe;
	// a disabled pin idles low on out and is never enabled
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			out_q <= PIN_NIBBLE_RST;
		end else begin
			out_q <= val_d & drv_d;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			oe_n_q <= '1;
		end else begin
			oe_n_q <= ~drv_d;
		end
	end

	// pins are synchronous inputs, so one flop stage is enough
	// a read returns the level seen one edge before its strobe
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			in_q <= PIN_NIBBLE_RST;
		end else begin
			in_q <= gpio_in;
		end
	end

	// stream length is the disable width, so word and register agree
	serial_disable_loader #(
		.LEN(CLK_DIS_W)
	) u_loader (
		.mclk(mclk),
		.rst_n(rst_n),
		.sec_rst(sec_rst),
		.ser_in(ser_in),
		.load(ser_load),
		.word(ser_word)
	);

	// the serial load wins over a configuration write in the same cycle
	always_comb begin
		dis_d = dis_q;
		if (ser_load) begin
			dis_d = ser_word;
		end else begin
			if (wr_clk_lo) begin
				dis_d[7:0] = cfg_req.wdata[7:0];
			end
			if (wr_clk_hi) begin
				dis_d[CLK_DIS_W-1:8] = cfg_req.wdata[CLK_DIS_W-1:8];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			dis_q <= CLK_DIS_RST;
		end else begin
			dis_q <= dis_d;
		end
	end

	// dword images as software reads them; reserved bits are constants
	always_comb begin
		pin_img = '0;
		pin_img[VAL_CLR_LSB +: PINS] = val_clr_q;
		pin_img[VAL_SET_LSB +: PINS] = val_set_q;
		pin_img[DRV_CLR_LSB +: PINS] = drv_clr_q;
		pin_img[DRV_SET_LSB +: PINS] = drv_set_q;
		pin_img[IN_RSVD_LSB +: 4] = IN_RSVD_VAL;
		pin_img[IN_PIN_LSB +: PINS] = in_q;
	end

	always_comb begin
		clk_img = '0;
		clk_img[CLK_DIS_W-1:0] = dis_q;
		clk_img[CLK_RSVD_LSB +: 2] = CLK_RSVD_VAL;
	end

	// read mux; unmapped dwords read zero, whatever the lane enables
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rdata_q <= '0;
		end else if (cfg_req.rd && hit_pin) begin
			rdata_q <= pin_img;
		end else if (cfg_req.rd && hit_clk) begin
			rdata_q <= clk_img;
		end else begin
			rdata_q <= '0;
		end
	end

	// one answer per read strobe, with no wait states
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= cfg_req.rd;
		end
	end

	// secondary clocks run at half of mclk from one shared phase
	// a shared phase keeps all outputs aligned at the cost of rate
	always_comb begin
		case (ph_q)
			PH_HIGH: ph_d = PH_LOW;
			PH_LOW: ph_d = PH_HIGH;
			default: ph_d = PH_HIGH;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ph_q <= PH_HIGH;
		end else begin
			ph_q <= ph_d;
		end
	end

	assign ph_next = (ph_d == PH_HIGH);

	// slot clocks need both card-present bits set to stop
	always_comb begin
		slot_stop = '0;
		for (int s = 0; s < SLOT_N; s++) begin
			slot_stop[s] = &dis_q[2*s +: 2];
		end
	end

	// device clocks stop on one bit; stopping the last one, which feeds
	// the bridge's own secondary input, stalls the secondary side
	always_comb begin
		dev_stop = '0;
		for (int d = 0; d < DEV_N; d++) begin
			dev_stop[d] = dis_q[2*SLOT_N+d];
		end
	end

	// outputs beyond the documented ten never stop
	always_comb begin
		gate_dis = '0;
		gate_dis[SLOT_N-1:0] = slot_stop;
		gate_dis[CLK_OUT_N-1:SLOT_N] = dev_stop;
	end

	// one cell per output, each with its own enable flop
	for (genvar g = 0; g < CLKS; g++) begin : g_gate
		clock_gate_cell u_cell (
			.mclk(mclk),
			.rst_n(rst_n),
			.ph_next(ph_next),
			.dis(gate_dis[g]),
			.clk_o(s_clk_o[g])
		);
	end

	assign gpio_out = out_q;
	assign gpio_oe_n = oe_n_q;
	assign cfg_rdata = rdata_q;
	assign cfg_rvalid = rvalid_q;
endmodule

// file: testbench/pin_gate_properties.sv
// assertions on the ports of the pin port and clock gating block
// assumes a bind to the top module and the single clock mclk
`timescale 1ns/1ps
module pin_gate_properties import bridge_pins_pkg::*; #(
	parameter int PINS = 4,
	parameter int CLKS = 10
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire cfg_req_t cfg_req,
	input wire logic [31:0] cfg_rdata,
	input wire logic cfg_rvalid,
	input wire logic [PINS-1:0] gpio_in,
	input wire logic [PINS-1:0] gpio_out,
	input wire logic [PINS-1:0] gpio_oe_n,
	input wire logic sec_rst,
	input wire ser_bit_t ser_in,
	input wire logic [CLKS-1:0] s_clk_o
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic pw, vw, ew;
	assign pw = cfg_req.wr && cfg_req.addr[7:2] == DW_PIN_ADDR[7:2];
	assign vw = pw && !cfg_req.be_n[1] && cfg_req.be_n[2];
	assign ew = pw && !cfg_req.be_n[2];
	a_undriven_low: assert property ((gpio_out & gpio_oe_n) == '0)
		else $error("undriven pin high");
	a_only_by_write: assert property ($changed(gpio_oe_n)
		|-> $past(cfg_req.wr)) else $error("enable moved alone");
	a_set_drives_high: assert property (vw |=> ((gpio_out ^ ~gpio_oe_n)
		& $past(cfg_req.wdata[15:12])) == '0) else $error("set failed");
	a_clear_drives_low: assert property (vw |=> (gpio_out &
		$past(cfg_req.wdata[11:8]) &
		~$past(cfg_req.wdata[15:12])) == '0)
		else $error("clear failed");
	a_enable_set: assert property (ew |=> (gpio_oe_n &
		$past(cfg_req.wdata[23:20])) == '0) else $error("enable failed");
	a_enable_clear: assert property (ew |=> (~gpio_oe_n &
		$past(cfg_req.wdata[19:16]) &
		~$past(cfg_req.wdata[23:20])) == '0)
		else $error("disable failed");
	a_clk_reserved: assert property (cfg_req.rd &&
		cfg_req.addr[7:2] == DW_CLK_ADDR[7:2] |=> cfg_rdata[15:14] == 2'h3)
		else $error("reserved bits wrong");
	a_no_runt: assert property ((s_clk_o | $past(s_clk_o)) == '1)
		else $error("clock low too long");
endmodule
bind bridge_pins_and_slot_clock_gating pin_gate_properties #(.PINS(PINS),
	.CLKS(CLKS)) i_props (.mclk(mclk), .rst_n(rst_n), .cfg_req(cfg_req),
	.cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .gpio_in(gpio_in),
	.gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .sec_rst(sec_rst),
	.ser_in(ser_in), .s_clk_o(s_clk_o));

// file: testbench/prsnt_stream_source.sv
// board logic shifting the clock disables in, bit 0 first
// assumes start is pulsed while secondary reset is high
`timescale 1ns/1ps
module prsnt_stream_source import bridge_pins_pkg::*; (
	input wire logic mclk,
	input wire logic start,
	input wire logic [13:0] word,
	output ser_bit_t ser
);
	logic [13:0] sh_q = 14'h0000;
	logic [4:0] cnt_q = 5'h00;
	assign ser = '{cnt_q != 5'h00, sh_q[0]};
	// idle data toggles so a stale bit never looks live
	always @(posedge mclk) begin
		if (start) begin
			sh_q <= word;
			cnt_q <= 5'h0E;
		end else if (cnt_q != 5'h00) begin
			sh_q <= {~sh_q[0], sh_q[13:1]};
			cnt_q <= cnt_q - 5'h01;
		end else
			sh_q[0] <= ~sh_q[0];
	end
endmodule

// file: testbench/test_bridge_pins_and_slot_clock_gating.sv
// bench for the pin port and clock gating block, driven at falling edges
// assumes the board source model feeds the serial disables
`timescale 1ns/1ps
module test_bridge_pins_and_slot_clock_gating import bridge_pins_pkg::*; ();
	typedef struct packed {
		logic [3:0] be_n;
		logic [31:0] wd;
		logic [7:0] pins;
	} row_t;
	// pins holds the value nibble, then the active low enable nibble
	row_t rows [7] = '{'{4'hB, 32'h0030_0000, 8'h0C},
		'{4'hD, 32'h0000_5000, 8'h1C}, '{4'hD, 32'h0000_0000, 8'h1C},
		'{4'hB, 32'h00C0_0000, 8'h50}, '{4'hD, 32'h0000_0500, 8'h00},
		'{4'hD, 32'h0000_3300, 8'h30}, '{4'hB, 32'h0003_0000, 8'h03}};
	logic mclk = 1'b0, rst_n = 1'b0, sec_rst = 1'b0, start = 1'b0, rv;
	cfg_req_t cfg_req = '0;
	logic [31:0] cfg_rdata;
	logic [3:0] gpio_in = 4'hA, gpio_out, gpio_oe_n;
	logic [9:0] s_clk_o, acc;
	ser_bit_t ser_in;
	int miscompares = 0, checked = 0, cycles = 0;
	always #12.5 mclk = ~mclk;
	bridge_pins_and_slot_clock_gating i_dut (.mclk(mclk), .rst_n(rst_n),
		.cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_rvalid(rv),
		.gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
		.sec_rst(sec_rst), .ser_in(ser_in), .s_clk_o(s_clk_o));
	// slots 0 and 2 empty, slot 1 half present, device clocks 4 and 9 off
	prsnt_stream_source i_src (.mclk(mclk), .start(start),
		.word(14'h213B), .ser(ser_in));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cfg(input logic w, input logic [7:0] a,
		input logic [3:0] be, input logic [31:0] d);
		@(negedge mclk);
		cfg_req = '{w, !w, a, be, d};
		@(negedge mclk);
		cfg_req = '0;
	endtask
	// a missing answer turns the data into a marker that never matches
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		cfg(1'b0, a, 4'h0, 32'h0000_0000);
		chk(rv ? cfg_rdata : 32'hDEAD_BEEF, exp);
	endtask
	task automatic gate(input logic [9:0] stop);
		repeat (4) @(negedge mclk);
		acc = '0;
		repeat (6) @(negedge mclk) acc = acc | ~s_clk_o;
		chk({22'h0, acc}, {22'h0, ~stop});
	endtask
	task automatic print_verdict;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			print_verdict;
		end
	end
	initial begin
		repeat (5) @(negedge mclk);
		rst_n = 1'b1;
		chk({28'h0, gpio_oe_n}, 32'hF);
		repeat (2) @(negedge mclk);
		rd(8'h64, 32'hA000_0000);
		foreach (rows[i]) begin
			cfg(1'b1, 8'h65, rows[i].be_n, rows[i].wd);
			chk({24'h0, gpio_out, gpio_oe_n},
				{24'h0, rows[i].pins});
		end
		rd(8'h64, 32'hA003_3300);
		gpio_in = 4'h5;
		repeat (2) @(negedge mclk);
		rd(8'h67, 32'h5003_3300);
		rd(8'h68, 32'h0000_C000);
		cfg(1'b1, 8'h68, 4'hC, 32'h0000_2107);
		gate(10'h211);
		rd(8'h68, 32'h0000_E107);
		sec_rst = 1'b1;
		start = 1'b1;
		@(negedge mclk);
		start = 1'b0;
		repeat (20) @(negedge mclk);
		sec_rst = 1'b0;
		gate(10'h215);
		rd(8'h68, 32'h0000_E13B);
		rst_n = 1'b0;
		repeat (2) @(negedge mclk);
		rst_n = 1'b1;
		chk({28'h0, gpio_oe_n}, 32'hF);
		repeat (2) @(negedge mclk);
		rd(8'h64, 32'h5000_0000);
		gate(10'h000);
		print_verdict;
	end
endmodule
